// ### fss_pkg.sv
`default_nettype none
package fss_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int RESET_STAGE_MS = 100;
    localparam int LOCKOUT_S = 5;
    localparam int LOCKOUT_MS = LOCKOUT_S * MS_PER_S;
    localparam logic [15:0] FREQ_OFFSET_PPM = 16'h0640;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PRE_MS = 8'h08;
    localparam logic [7:0] OFS_FAULT_MS = 8'h0C;
    localparam logic [7:0] OFS_POST_MS = 8'h10;
    localparam logic [7:0] OFS_LINK_DLY = 8'h14;
    localparam logic [7:0] OFS_QTY_BASE = 8'h40;
    localparam logic [7:0] OFS_QTY_LAST = 8'h9C;
    localparam int QTY_WORDS = 24;
    localparam logic [4:0] QTY_PRE_BASE = 5'h00;
    localparam logic [4:0] QTY_FAULT_BASE = 5'h08;
    localparam logic [4:0] QTY_POST_BASE = 5'h10;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_TRIP_POLICY = 2;
    localparam int CTRL_FP_EN = 3;
    localparam int CTRL_XS_EN = 4;
    localparam logic [15:0] PRE_MS_RESET = 16'h03E8;
    localparam logic [15:0] FAULT_MS_RESET = 16'h03E8;
    localparam logic [15:0] POST_MS_RESET = 16'h03E8;
    localparam logic [15:0] LINK_DLY_RESET = 16'h0064;
    // ------------------------------------------------------------
    // State codes and states
    // ------------------------------------------------------------
    localparam logic [2:0] CODE_NORMAL = 3'h0;
    localparam logic [2:0] CODE_PRE = 3'h1;
    localparam logic [2:0] CODE_FAULT = 3'h2;
    localparam logic [2:0] CODE_POST = 3'h3;
    localparam logic [2:0] CODE_RESET = 3'h4;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LINK_WAIT, ST_RST_PRE, ST_PRE, ST_FAULT, ST_POST, ST_RST_POST
    } fss_state_type;
endpackage
`default_nettype wire

// ### fss_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module fss_remote_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Bench commands
    input wire logic sendStart,
    input wire logic sendForcePost,
    input wire logic sendAbort,
    // Triggers from the local device
    input wire logic startTrig,
    input wire logic forcePostTrig,
    input wire logic abortTrig,
    // Events towards the local device and trigger counts
    output logic startOut,
    output logic forcePostOut,
    output logic abortOut,
    output int startSeen,
    output int forcePostSeen,
    output int abortSeen
);
    // One-cycle remote events; incoming triggers are counted
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            startOut <= 1'b0;
            forcePostOut <= 1'b0;
            abortOut <= 1'b0;
            startSeen <= 0;
            forcePostSeen <= 0;
            abortSeen <= 0;
        end else begin
            startOut <= sendStart;
            forcePostOut <= sendForcePost;
            abortOut <= sendAbort;
            startSeen <= startSeen + int'(startTrig);
            forcePostSeen <= forcePostSeen + int'(forcePostTrig);
            abortSeen <= abortSeen + int'(abortTrig);
        end
    end
endmodule // fss_remote_model
`default_nettype wire

// ### fss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
//Behaviour
//- A run passes pre-fault, fault, post-fault in this order.
//- A 100 ms reset stage precedes pre-fault and follows post-fault.
//- State code: 0 normal, 1 pre, 2 fault, 3 post, 4 reset.
//- Phase durations and simulated quantities per phase are programmable.
//- Phase current above threshold aborts a run at once.
//- After overcurrent abort, restart refused until 5 s below threshold.
//- Either external block input prevents the simulator from starting.
//- Force-to-post in pre-fault or fault jumps to post-fault.
//- Energy counters halt while a run is active.
//- Simulated voltages are phase-to-neutral while a run is active.
//- Simulated frequency sits 0.16 percent above rated.
//- Without trip policy, trip commands are suppressed during a run.
//- Manual start without force-to-post runs the whole sequence.
//- Manual stop ends the run and returns to normal.
//- External start input starts a run unless blocked or overcurrent.
//- Link active: trigger remote, wait link delay, then start.
//- Link active: signal remote force-post, wait delay, then post-fault.
//- Link inactive at start: local run only, no trigger.
//- Link lost during run: continue, treat remote currents as zero.
//- Overcurrent abort reaches both devices with no link delay.
module fss_sequencer #(
    parameter int MS_CYCLES = fss_pkg::MS_CYCLES,
    parameter int RESET_STAGE_MS = fss_pkg::RESET_STAGE_MS,
    parameter int LOCKOUT_MS = fss_pkg::LOCKOUT_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Assigned signals from pins
    input wire logic externalBlockInputOne,
    input wire logic externalBlockInputTwo,
    input wire logic forceToPostInput,
    input wire logic externalSimStartInput,
    // Protection side
    input wire logic phaseOverThreshold,
    input wire logic protTripDecision,
    input wire logic [2:0] simChanSel,
    output logic breakerTripCommand,
    output logic protResetStage,
    output logic simActive,
    output logic energyCountHalt,
    output logic voltPhaseNeutral,
    output logic [15:0] simFreqOffsetPpm,
    output logic [2:0] stateCode,
    output logic [31:0] simChanValue,
    // Protection link
    input wire logic linkActive,
    input wire logic remoteStartIn,
    input wire logic remoteForcePostIn,
    input wire logic remoteAbortIn,
    output logic remoteStartTrigger,
    output logic remoteForcePostTrigger,
    output logic remoteAbortTrigger,
    output logic remoteCurrentZero
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        fss_pkg::fss_state_type st;
        logic [15:0] msDiv;
        logic [15:0] phaseCnt;
        logic [15:0] linkCnt;
        logic fpPending;
        logic lockout;
        logic [15:0] lockCnt;
        logic [1:0] blk1;
        logic [1:0] blk2;
        logic [1:0] fpost;
        logic [1:0] xstart;
        logic fpostD;
        logic xstartD;
        logic tripPolicy;
        logic fpEn;
        logic xsEn;
        logic [15:0] preMs;
        logic [15:0] faultMs;
        logic [15:0] postMs;
        logic [15:0] linkDly;
        logic remStart;
        logic remFp;
        logic remAbort;
        logic trip;
        logic [2:0] code;
        logic [31:0] rdata;
        logic [31:0] chanVal;
    } fss_regs_type;

    localparam fss_regs_type REGS_RESET = '{
        st: fss_pkg::ST_IDLE,
        preMs: fss_pkg::PRE_MS_RESET,
        faultMs: fss_pkg::FAULT_MS_RESET,
        postMs: fss_pkg::POST_MS_RESET,
        linkDly: fss_pkg::LINK_DLY_RESET,
        default: '0
    };

    fss_regs_type s;
    fss_regs_type next_s;
    logic [31:0] qtyTable [0:fss_pkg::QTY_WORDS-1];

    logic msTick;
    logic wrAcc;
    logic qtyHit;
    logic mapped;
    logic [4:0] qtyIdx;
    logic [4:0] chanIdx;
    logic startCmd;
    logic stopCmd;
    logic fpRise;
    logic xsRise;
    logic blocked;
    logic startOk;
    logic running;
    logic abort;
    logic phaseDone;
    logic [15:0] curDur;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        qtyHit = (paddr >= fss_pkg::OFS_QTY_BASE) && (paddr <= fss_pkg::OFS_QTY_LAST) && (paddr[1:0] == 2'h0);
        qtyIdx = 5'((paddr - fss_pkg::OFS_QTY_BASE) >> 2);
        if (paddr == fss_pkg::OFS_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == fss_pkg::OFS_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == fss_pkg::OFS_PRE_MS || paddr == fss_pkg::OFS_FAULT_MS) begin
            mapped = 1'b1;
        end else if (paddr == fss_pkg::OFS_POST_MS || paddr == fss_pkg::OFS_LINK_DLY) begin
            mapped = 1'b1;
        end else begin
            mapped = qtyHit;
        end
    end

    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign wrAcc = psel & penable & pwrite & mapped;
    assign startCmd = wrAcc && paddr == fss_pkg::OFS_CTRL && pwdata[fss_pkg::CTRL_START];
    assign stopCmd = wrAcc && paddr == fss_pkg::OFS_CTRL && pwdata[fss_pkg::CTRL_STOP];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign msTick = (s.msDiv == 16'(MS_CYCLES - 1));
    assign fpRise = s.fpEn & s.fpost[1] & ~s.fpostD;
    assign xsRise = s.xsEn & s.xstart[1] & ~s.xstartD;
    assign blocked = s.blk1[1] | s.blk2[1];
    assign startOk = ~blocked & ~phaseOverThreshold & ~s.lockout;
    assign running = (s.st != fss_pkg::ST_IDLE) && (s.st != fss_pkg::ST_LINK_WAIT);
    assign abort = (s.st != fss_pkg::ST_IDLE) && (phaseOverThreshold | remoteAbortIn);
    assign phaseDone = msTick && ((s.phaseCnt + 16'h0001) >= curDur);

    always_comb begin
        case (s.st)
            fss_pkg::ST_PRE: curDur = s.preMs;
            fss_pkg::ST_FAULT: curDur = s.faultMs;
            fss_pkg::ST_POST: curDur = s.postMs;
            default: curDur = 16'(RESET_STAGE_MS);
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.remStart = 1'b0;
        next_s.remFp = 1'b0;
        next_s.remAbort = 1'b0;
        next_s.blk1 = {s.blk1[0], externalBlockInputOne};
        next_s.blk2 = {s.blk2[0], externalBlockInputTwo};
        next_s.fpost = {s.fpost[0], forceToPostInput};
        next_s.xstart = {s.xstart[0], externalSimStartInput};
        next_s.fpostD = s.fpost[1];
        next_s.xstartD = s.xstart[1];
        next_s.msDiv = msTick ? 16'h0000 : s.msDiv + 16'h0001;
        // Register writes
        if (wrAcc) begin
            if (paddr == fss_pkg::OFS_CTRL) begin
                next_s.tripPolicy = pwdata[fss_pkg::CTRL_TRIP_POLICY];
                next_s.fpEn = pwdata[fss_pkg::CTRL_FP_EN];
                next_s.xsEn = pwdata[fss_pkg::CTRL_XS_EN];
            end else if (paddr == fss_pkg::OFS_PRE_MS) begin
                next_s.preMs = pwdata[15:0];
            end else if (paddr == fss_pkg::OFS_FAULT_MS) begin
                next_s.faultMs = pwdata[15:0];
            end else if (paddr == fss_pkg::OFS_POST_MS) begin
                next_s.postMs = pwdata[15:0];
            end else if (paddr == fss_pkg::OFS_LINK_DLY) begin
                next_s.linkDly = pwdata[15:0];
            end
        end
        // Phase sequence
        case (s.st)
            fss_pkg::ST_IDLE: begin
                if ((startCmd | xsRise) && startOk) begin
                    if (linkActive) begin
                        next_s.remStart = 1'b1;
                        next_s.linkCnt = 16'h0000;
                        next_s.st = fss_pkg::ST_LINK_WAIT;
                    end else begin
                        next_s.st = fss_pkg::ST_RST_PRE;
                    end
                end else if (remoteStartIn && startOk) begin
                    next_s.st = fss_pkg::ST_RST_PRE;
                end
            end
            fss_pkg::ST_LINK_WAIT: begin
                if (s.linkCnt >= s.linkDly) begin
                    next_s.st = fss_pkg::ST_RST_PRE;
                end else begin
                    next_s.linkCnt = s.linkCnt + 16'h0001;
                end
            end
            fss_pkg::ST_RST_PRE: begin
                if (phaseDone) begin
                    next_s.st = fss_pkg::ST_PRE;
                end
            end
            fss_pkg::ST_PRE, fss_pkg::ST_FAULT: begin
                if (s.fpPending) begin
                    if (s.linkCnt >= s.linkDly) begin
                        next_s.st = fss_pkg::ST_POST;
                    end else begin
                        next_s.linkCnt = s.linkCnt + 16'h0001;
                    end
                end else if (fpRise && linkActive) begin
                    next_s.remFp = 1'b1;
                    next_s.fpPending = 1'b1;
                    next_s.linkCnt = 16'h0000;
                end else if (fpRise || remoteForcePostIn) begin
                    next_s.st = fss_pkg::ST_POST;
                end else if (phaseDone) begin
                    next_s.st = (s.st == fss_pkg::ST_PRE) ? fss_pkg::ST_FAULT : fss_pkg::ST_POST;
                end
            end
            fss_pkg::ST_POST: begin
                if (phaseDone) begin
                    next_s.st = fss_pkg::ST_RST_POST;
                end
            end
            fss_pkg::ST_RST_POST: begin
                if (phaseDone) begin
                    next_s.st = fss_pkg::ST_IDLE;
                end
            end
            default: next_s.st = fss_pkg::ST_IDLE;
        endcase
        // Stop and abort override the sequence
        if (stopCmd || abort) begin
            next_s.st = fss_pkg::ST_IDLE;
        end
        if (abort && phaseOverThreshold) begin
            next_s.lockout = 1'b1;
            next_s.remAbort = linkActive;
        end
        if (next_s.st != fss_pkg::ST_PRE && next_s.st != fss_pkg::ST_FAULT) begin
            next_s.fpPending = 1'b0;
        end
        next_s.phaseCnt = (next_s.st != s.st) ? 16'h0000 : (msTick ? s.phaseCnt + 16'h0001 : s.phaseCnt);
        // Restart lockout after overcurrent
        if (phaseOverThreshold) begin
            next_s.lockCnt = 16'h0000;
        end else if (s.lockout && msTick) begin
            if (s.lockCnt >= 16'(LOCKOUT_MS - 1)) begin
                next_s.lockout = 1'b0;
            end else begin
                next_s.lockCnt = s.lockCnt + 16'h0001;
            end
        end
        // Outputs
        case (next_s.st)
            fss_pkg::ST_PRE: next_s.code = fss_pkg::CODE_PRE;
            fss_pkg::ST_FAULT: next_s.code = fss_pkg::CODE_FAULT;
            fss_pkg::ST_POST: next_s.code = fss_pkg::CODE_POST;
            fss_pkg::ST_RST_PRE, fss_pkg::ST_RST_POST: next_s.code = fss_pkg::CODE_RESET;
            default: next_s.code = fss_pkg::CODE_NORMAL;
        endcase
        next_s.trip = protTripDecision & (s.tripPolicy | ~running);
        next_s.chanVal = (chanIdx != 5'h1F) ? qtyTable[chanIdx] : 32'h0000_0000;
        // Read data captured in setup
        if (psel && !penable) begin
            if (paddr == fss_pkg::OFS_CTRL) begin
                next_s.rdata = {27'h0, s.xsEn, s.fpEn, s.tripPolicy, 2'h0};
            end else if (paddr == fss_pkg::OFS_STATUS) begin
                next_s.rdata = {25'h0, phaseOverThreshold, blocked, s.lockout, running, s.code};
            end else if (paddr == fss_pkg::OFS_PRE_MS) begin
                next_s.rdata = {16'h0, s.preMs};
            end else if (paddr == fss_pkg::OFS_FAULT_MS) begin
                next_s.rdata = {16'h0, s.faultMs};
            end else if (paddr == fss_pkg::OFS_POST_MS) begin
                next_s.rdata = {16'h0, s.postMs};
            end else if (paddr == fss_pkg::OFS_LINK_DLY) begin
                next_s.rdata = {16'h0, s.linkDly};
            end else if (qtyHit) begin
                next_s.rdata = qtyTable[qtyIdx];
            end else begin
                next_s.rdata = 32'h0000_0000;
            end
        end
    end

    always_comb begin
        case (s.st)
            fss_pkg::ST_PRE: chanIdx = fss_pkg::QTY_PRE_BASE + {2'h0, simChanSel};
            fss_pkg::ST_FAULT: chanIdx = fss_pkg::QTY_FAULT_BASE + {2'h0, simChanSel};
            fss_pkg::ST_POST: chanIdx = fss_pkg::QTY_POST_BASE + {2'h0, simChanSel};
            default: chanIdx = 5'h1F;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s <= REGS_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Simulated quantity table
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (wrAcc && qtyHit) begin
            qtyTable[qtyIdx] <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s.rdata;
    assign breakerTripCommand = s.trip;
    assign protResetStage = (s.st == fss_pkg::ST_RST_PRE) || (s.st == fss_pkg::ST_RST_POST);
    assign simActive = running;
    assign energyCountHalt = running;
    assign voltPhaseNeutral = running;
    assign simFreqOffsetPpm = fss_pkg::FREQ_OFFSET_PPM;
    assign stateCode = s.code;
    assign simChanValue = s.chanVal;
    assign remoteStartTrigger = s.remStart;
    assign remoteForcePostTrigger = s.remFp;
    assign remoteAbortTrigger = s.remAbort;
    assign remoteCurrentZero = running & ~linkActive;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_order;
        s.st == fss_pkg::ST_FAULT |-> $past(s.st) == fss_pkg::ST_PRE || $past(s.st) == fss_pkg::ST_FAULT;
    endproperty
    a_order: assert property (p_order) else $error("fault not entered from pre-fault");

    property p_reset_before_pre;
        s.st == fss_pkg::ST_PRE && $past(s.st) != fss_pkg::ST_PRE |-> $past(s.st) == fss_pkg::ST_RST_PRE;
    endproperty
    a_reset_before_pre: assert property (p_reset_before_pre) else $error("pre-fault without reset stage");

    property p_code;
        protResetStage == (stateCode == fss_pkg::CODE_RESET);
    endproperty
    a_code: assert property (p_code) else $error("reset code mismatch");

    property p_abort;
        running && phaseOverThreshold |=> s.st == fss_pkg::ST_IDLE && s.lockout;
    endproperty
    a_abort: assert property (p_abort) else $error("overcurrent did not abort");

    property p_lockout;
        s.st == fss_pkg::ST_IDLE && s.lockout |=> s.st == fss_pkg::ST_IDLE;
    endproperty
    a_lockout: assert property (p_lockout) else $error("start during lockout");

    property p_block;
        s.st == fss_pkg::ST_IDLE && blocked |=> s.st == fss_pkg::ST_IDLE;
    endproperty
    a_block: assert property (p_block) else $error("start while blocked");

    property p_force_post;
        (s.st == fss_pkg::ST_PRE || s.st == fss_pkg::ST_FAULT) && fpRise && !s.fpPending && !linkActive
            && !abort && !stopCmd |=> s.st == fss_pkg::ST_POST;
    endproperty
    a_force_post: assert property (p_force_post) else $error("force-to-post ignored");

    property p_trip_block;
        running && !s.tripPolicy && protTripDecision |=> !breakerTripCommand;
    endproperty
    a_trip_block: assert property (p_trip_block) else $error("trip passed in no-trip policy");

    property p_stop;
        stopCmd |=> s.st == fss_pkg::ST_IDLE ##1 stateCode == fss_pkg::CODE_NORMAL;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not obeyed");

    property p_link_start;
        s.st == fss_pkg::ST_IDLE && next_s.st == fss_pkg::ST_LINK_WAIT |=> remoteStartTrigger && s.st == fss_pkg::ST_LINK_WAIT;
    endproperty
    a_link_start: assert property (p_link_start) else $error("remote start trigger missing");

    property p_local_start;
        s.st == fss_pkg::ST_IDLE && startCmd && startOk && !linkActive |=> s.st == fss_pkg::ST_RST_PRE && !remoteStartTrigger;
    endproperty
    a_local_start: assert property (p_local_start) else $error("stand-alone start wrong");

    property p_abort_remote;
        abort && phaseOverThreshold && linkActive |=> remoteAbortTrigger;
    endproperty
    a_abort_remote: assert property (p_abort_remote) else $error("abort not sent to remote");

    property p_idle_normal;
        s.st == fss_pkg::ST_IDLE |-> stateCode == fss_pkg::CODE_NORMAL && !simActive;
    endproperty
    a_idle_normal: assert property (p_idle_normal) else $error("idle not normal");
endmodule // fss_sequencer
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] CTRL = fss_pkg::OFS_CTRL;
    logic mclk, nrst, psel, penable, pwrite, blk1, blk2, fPost, xStart, overI, tripDec, link, slvErr;
    logic pready, pslverr, breaker_trip_command, simAct, eHalt, vPn, rsT, rfT, raT, rsI, rfI, raI, remZero, sS, sF, sA, rsStg;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, chanVal, rd;
    logic [15:0] freqOfs;
    logic [2:0] code;
    int n_mismatch, compares, cyc, stC, fpC, abC;
    fss_sequencer #(.MS_CYCLES(10), .RESET_STAGE_MS(3), .LOCKOUT_MS(5)) DUT (.mclk(mclk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .externalBlockInputOne(blk1), .externalBlockInputTwo(blk2),
        .forceToPostInput(fPost), .externalSimStartInput(xStart), .phaseOverThreshold(overI),
        .protTripDecision(tripDec), .simChanSel(3'h0), .breakerTripCommand(breaker_trip_command), .protResetStage(rsStg),
        .simActive(simAct), .energyCountHalt(eHalt), .voltPhaseNeutral(vPn), .simFreqOffsetPpm(freqOfs),
        .stateCode(code), .simChanValue(chanVal), .linkActive(link), .remoteStartIn(rsI),
        .remoteForcePostIn(rfI), .remoteAbortIn(raI), .remoteStartTrigger(rsT),
        .remoteForcePostTrigger(rfT), .remoteAbortTrigger(raT), .remoteCurrentZero(remZero));
    fss_remote_model remote (.mclk(mclk), .nrst(nrst), .sendStart(sS), .sendForcePost(sF), .sendAbort(sA),
        .startTrig(rsT), .forcePostTrig(rfT), .abortTrig(raT), .startOut(rsI), .forcePostOut(rfI),
        .abortOut(raI), .startSeen(stC), .forcePostSeen(fpC), .abortSeen(abC));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Bench tasks
    // ------------------------------------------------------------
    task stop_test;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test;
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task waitCode(input logic [2:0] c, input int lim);
        int n;
        n = 0;
        while (code !== c && n < lim) begin
            @(posedge mclk);
            n++;
        end
        chk("stateCode", {29'h0, c}, {29'h0, code});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, blk1, blk2, fPost, xStart, overI, tripDec, link, sS, sF, sA} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        apb(1'b0, fss_pkg::OFS_PRE_MS, 32'h0);
        chk("preMs", 32'h000003E8, rd);
        apb(1'b0, fss_pkg::OFS_LINK_DLY, 32'h0);
        chk("linkDly", 32'h00000064, rd);
        apb(1'b0, 8'hFC, 32'h0);
        chk("pslverr", 32'h1, {31'h0, slvErr});
        apb(1'b1, fss_pkg::OFS_PRE_MS, 32'h2);
        apb(1'b1, fss_pkg::OFS_FAULT_MS, 32'h2);
        apb(1'b1, fss_pkg::OFS_POST_MS, 32'h2);
        apb(1'b1, fss_pkg::OFS_LINK_DLY, 32'h4);
        apb(1'b1, 8'h60, 32'h00001234);
        apb(1'b1, CTRL, 32'h1);
        waitCode(3'h4, 5);
        repeat (15) @(posedge mclk);
        chk("stateCode", 32'h4, {29'h0, code});
        chk("protResetStage", 32'h1, {31'h0, rsStg});
        waitCode(3'h1, 20);
        waitCode(3'h2, 40);
        tripDec <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("energyCountHalt", 32'h1, {31'h0, eHalt});
        chk("simActive", 32'h1, {31'h0, simAct});
        chk("voltPhaseNeutral", 32'h1, {31'h0, vPn});
        chk("simFreqOffsetPpm", 32'h0640, {16'h0, freqOfs});
        chk("simChanValue", 32'h00001234, chanVal);
        chk("breakerTripCommand", 32'h0, {31'h0, breaker_trip_command});
        waitCode(3'h3, 40);
        waitCode(3'h4, 40);
        waitCode(3'h0, 40);
        repeat (3) @(posedge mclk);
        chk("breakerTripCommand", 32'h1, {31'h0, breaker_trip_command});
        chk("energyCountHalt", 32'h0, {31'h0, eHalt});
        tripDec <= 1'b0;
        apb(1'b1, CTRL, 32'h1);
        waitCode(3'h1, 60);
        apb(1'b1, CTRL, 32'h2);
        waitCode(3'h0, 3);
        link <= 1'b1;
        apb(1'b1, CTRL, 32'h1);
        repeat (3) @(posedge mclk);
        chk("stateCode", 32'h0, {29'h0, code});
        waitCode(3'h4, 8);
        chk("startTrig", 32'h1, stC);
        waitCode(3'h1, 40);
        overI <= 1'b1;
        waitCode(3'h0, 2);
        overI <= 1'b0;
        @(posedge mclk);
        chk("abortTrig", 32'h1, abC);
        apb(1'b1, CTRL, 32'h1);
        repeat (5) @(posedge mclk);
        chk("stateCode", 32'h0, {29'h0, code});
        repeat (60) @(posedge mclk);
        link <= 1'b0;
        apb(1'b1, CTRL, 32'h1);
        waitCode(3'h4, 5);
        chk("startTrig", 32'h1, stC);
        apb(1'b1, CTRL, 32'h2);
        waitCode(3'h0, 3);
        link <= 1'b1;
        sS <= 1'b1;
        @(posedge mclk);
        sS <= 1'b0;
        waitCode(3'h4, 5);
        waitCode(3'h1, 40);
        link <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("remoteCurrentZero", 32'h1, {31'h0, remZero});
        chk("stateCode", 32'h1, {29'h0, code});
        sF <= 1'b1;
        @(posedge mclk);
        sF <= 1'b0;
        waitCode(3'h3, 4);
        sA <= 1'b1;
        @(posedge mclk);
        sA <= 1'b0;
        waitCode(3'h0, 3);
        apb(1'b1, CTRL, 32'h1C);
        for (int i = 0; i < 2; i++) begin
            blk1 <= (i == 0);
            blk2 <= (i == 1);
            xStart <= 1'b1;
            repeat (8) @(posedge mclk);
            chk("stateCode", 32'h0, {29'h0, code});
            xStart <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        {blk1, blk2, link, xStart} <= 4'h3;
        waitCode(3'h4, 14);
        waitCode(3'h1, 40);
        {fPost, tripDec} <= 2'h3;
        repeat (4) @(posedge mclk);
        chk("stateCode", 32'h1, {29'h0, code});
        chk("breakerTripCommand", 32'h1, {31'h0, breaker_trip_command});
        waitCode(3'h3, 12);
        chk("forcePostTrig", 32'h1, fpC);
        {fPost, xStart} <= 2'h0;
        waitCode(3'h0, 80);
        link <= 1'b0;
        apb(1'b1, CTRL, 32'h1D);
        waitCode(3'h1, 60);
        fPost <= 1'b1;
        waitCode(3'h3, 5);
        chk("forcePostTrig", 32'h1, fpC);
        fPost <= 1'b0;
        waitCode(3'h0, 80);
        stop_test;
    end
endmodule // tb
`default_nettype wire
